// file: logic/cspi_defines.vh
`ifndef CSPI_DEFINES_VH
`define CSPI_DEFINES_VH
// pixel data width
`define CSPI_DATA_W 8
// capture mode codes
`define CSPI_MODE_EMB 2'h0
`define CSPI_MODE_GATED 2'h1
`define CSPI_MODE_NONGATED 2'h2
// embedded timing code preamble bytes
`define CSPI_PRE0 8'hFF
`define CSPI_PRE1 8'h00
// embedded code word bit positions
`define CSPI_XY_F 6
`define CSPI_XY_V 5
`define CSPI_XY_H 4
// buffer depth
`define CSPI_BUF_DEPTH 2
`endif

// file: logic/cspi_buf2.v
`timescale 1ns/1ps
`default_nettype none
`include "cspi_defines.vh"
// two-entry buffer, valid/ready on both sides
module cspi_buf2 (
  input wire clk,
  input wire rst,
  input wire [`CSPI_DATA_W:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [`CSPI_DATA_W:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [`CSPI_DATA_W:0] mem_reg [0:`CSPI_BUF_DEPTH-1]; // storage
  reg wr_ptr_reg; // write slot
  reg rd_ptr_reg; // read slot
  reg [1:0] count_reg; // entries held
  wire push; // accepted write
  wire pop; // accepted read
  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // pointer and count update
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (push & ~pop)
        count_reg <= count_reg + 2'h1;
      else if (pop & ~push)
        count_reg <= count_reg - 2'h1;
    end
  end
  // storage write, no reset needed on data
  always @(posedge clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data;
  end
endmodule // cspi_buf2
`default_nettype wire

// file: logic/cspi_top.v
`timescale 1ns/1ps
`default_nettype none
`include "cspi_defines.vh"
// How it works
// - embedded mode: strip codes, regenerate syncs
// - gated and non-gated: frame starts on frame sync rising edge
// - gated: pixel clock valid only line high
// - data sampled on valid pixel clock rise
// - gated: line sync low stops data acceptance
// - lines and frames repeat same sync pattern
// - non-gated: ignore line sync entirely
// - non-gated: every pixel clock inside the frame captures word
module cspi_top (
  input wire CORE_CLK,
  input wire RST,
  input wire [1:0] MODE_SEL,
  input wire FRAME_POL_INV,
  input wire LINE_POL_INV,
  input wire SENSOR_PIXEL_CLOCK,
  input wire SENSOR_FRAME_SYNC,
  input wire SENSOR_LINE_SYNC,
  input wire [`CSPI_DATA_W-1:0] SENSOR_DATA,
  output wire [`CSPI_DATA_W-1:0] PIX_DATA,
  output wire PIX_FRAME_START,
  output wire PIX_VALID,
  input wire PIX_READY,
  output reg FRAME_ACTIVE,
  output reg LINE_ACTIVE,
  output reg OVERFLOW
);
  localparam SYNC_W = `CSPI_DATA_W + 3;
  // three-stage synchronisers for all sensor inputs
  reg [SYNC_W-1:0] s1_reg; // first stage, read only by s2
  reg [SYNC_W-1:0] s2_reg; // second stage
  reg [SYNC_W-1:0] s3_reg; // third stage
  reg [SYNC_W-1:0] stable_reg; // value once s2 and s3 agree
  wire [SYNC_W-1:0] raw_in; // packed pins
  wire [SYNC_W-1:0] stable_next; // filtered next value
  assign raw_in = {SENSOR_PIXEL_CLOCK, SENSOR_FRAME_SYNC, SENSOR_LINE_SYNC, SENSOR_DATA};
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi = gi + 1)
    begin : g_flt
      // a bit changes only when stages two and three agree
      assign stable_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : stable_reg[gi];
    end
  endgenerate
  // synchroniser chain
  always @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      s1_reg <= {SYNC_W{1'b0}};
      s2_reg <= {SYNC_W{1'b0}};
      s3_reg <= {SYNC_W{1'b0}};
      stable_reg <= {SYNC_W{1'b0}};
    end
    else
    begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stable_reg <= stable_next;
    end
  end
  wire pclk_now = stable_next[SYNC_W-1]; // filtered pixel clock
  wire pclk_prev = stable_reg[SYNC_W-1]; // previous pixel clock
  wire [`CSPI_DATA_W-1:0] data_now = stable_next[`CSPI_DATA_W-1:0]; // filtered data
  // polarity applied to syncs
  wire fsync = stable_next[SYNC_W-2] ^ FRAME_POL_INV;
  wire lsync = stable_next[SYNC_W-3] ^ LINE_POL_INV;
  wire pclk_rise = pclk_now & ~pclk_prev;
  reg fsync_reg; // previous frame sync
  wire fsync_rise = fsync & ~fsync_reg;
  // embedded code detection
  reg [1:0] pre_reg; // count of preamble bytes seen
  reg emb_v_reg; // regenerated vertical blanking
  reg emb_h_reg; // regenerated horizontal blanking
  reg emb_start_reg; // frame start pending from codes
  wire mode_emb = (MODE_SEL == `CSPI_MODE_EMB);
  wire mode_gated = (MODE_SEL == `CSPI_MODE_GATED);
  wire mode_ng = (MODE_SEL == `CSPI_MODE_NONGATED);
  wire is_code_byte = (pre_reg == 2'h3); // fourth byte carries flags
  wire is_pre_byte = (pre_reg == 2'h0 && data_now == `CSPI_PRE0) ||
    ((pre_reg == 2'h1 || pre_reg == 2'h2) && data_now == `CSPI_PRE1);
  // pixel-clock edge qualified per mode
  wire pix_ok = mode_ng ? 1'b1 :
    mode_gated ? (lsync & FRAME_ACTIVE) :
    mode_emb ? (~emb_v_reg & ~emb_h_reg & ~is_pre_byte & ~is_code_byte) :
    1'b0;
  wire take = pclk_rise & pix_ok & (mode_ng ? FRAME_ACTIVE : 1'b1);
  // capture word and mark frame start in bit above data
  reg [`CSPI_DATA_W:0] cap_reg; // captured word with start flag
  reg cap_valid_reg; // capture pending
  reg start_pend_reg; // next word begins a frame
  wire buf_ready; // buffer can take a word
  // sync regeneration and capture
  always @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      fsync_reg <= 1'b0;
      pre_reg <= 2'h0;
      emb_v_reg <= 1'b1;
      emb_h_reg <= 1'b1;
      emb_start_reg <= 1'b0;
      FRAME_ACTIVE <= 1'b0;
      LINE_ACTIVE <= 1'b0;
      start_pend_reg <= 1'b0;
      cap_reg <= {(`CSPI_DATA_W+1){1'b0}};
      cap_valid_reg <= 1'b0;
      OVERFLOW <= 1'b0;
    end
    else
    begin
      fsync_reg <= fsync;
      // embedded code tracking on each pixel edge
      if (mode_emb & pclk_rise)
      begin
        if (is_code_byte)
        begin
          // flags byte: regenerate syncs
          pre_reg <= 2'h0;
          if (emb_v_reg & ~data_now[`CSPI_XY_V])
            emb_start_reg <= 1'b1;
          emb_v_reg <= data_now[`CSPI_XY_V];
          emb_h_reg <= data_now[`CSPI_XY_H];
        end
        else if (is_pre_byte)
          pre_reg <= pre_reg + 2'h1;
        else
          pre_reg <= 2'h0;
      end
      // frame and line state per mode
      case (MODE_SEL)
        `CSPI_MODE_EMB:
        begin
          FRAME_ACTIVE <= ~emb_v_reg;
          LINE_ACTIVE <= ~emb_v_reg & ~emb_h_reg;
        end
        `CSPI_MODE_GATED, `CSPI_MODE_NONGATED:
        begin
          if (fsync_rise)
            FRAME_ACTIVE <= 1'b1;
          else if (~fsync)
            FRAME_ACTIVE <= 1'b0;
          LINE_ACTIVE <= mode_gated & lsync & FRAME_ACTIVE;
        end
        default:
        begin
          FRAME_ACTIVE <= 1'b0;
          LINE_ACTIVE <= 1'b0;
        end
      endcase
      // mark first word of a frame
      if (fsync_rise & ~mode_emb)
        start_pend_reg <= 1'b1;
      else if (mode_emb & emb_start_reg)
      begin
        start_pend_reg <= 1'b1;
        emb_start_reg <= 1'b0;
      end
      // hand word toward buffer
      if (cap_valid_reg & buf_ready)
        cap_valid_reg <= 1'b0;
      if (take)
      begin
        if (cap_valid_reg & ~buf_ready)
          OVERFLOW <= 1'b1; // word lost, sticky until reset
        cap_reg <= {start_pend_reg, data_now};
        cap_valid_reg <= 1'b1;
        start_pend_reg <= 1'b0;
      end
    end
  end
  wire [`CSPI_DATA_W:0] out_word; // buffer output
  cspi_buf2 u_buf (
    .clk(CORE_CLK),
    .rst(RST),
    .in_data(cap_reg),
    .in_valid(cap_valid_reg),
    .in_ready(buf_ready),
    .out_data(out_word),
    .out_valid(PIX_VALID),
    .out_ready(PIX_READY)
  );
  assign PIX_DATA = out_word[`CSPI_DATA_W-1:0];
  assign PIX_FRAME_START = out_word[`CSPI_DATA_W];
endmodule // cspi_top
`default_nettype wire

// file: test/cspi_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the capture block
module cspi_chk (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [1:0] MODE_SEL,
  input wire logic FRAME_POL_INV,
  input wire logic LINE_POL_INV,
  input wire logic SENSOR_FRAME_SYNC,
  input wire logic SENSOR_LINE_SYNC,
  input wire logic [7:0] PIX_DATA,
  input wire logic PIX_VALID,
  input wire logic PIX_READY,
  input wire logic FRAME_ACTIVE,
  input wire logic LINE_ACTIVE,
  input wire logic OVERFLOW
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  wire fsl = SENSOR_FRAME_SYNC ^ FRAME_POL_INV; // frame level after polarity
  wire lsl = SENSOR_LINE_SYNC ^ LINE_POL_INV; // line level after polarity
  a_stall_holds: assert property (PIX_VALID && !PIX_READY |=> PIX_VALID && $stable(PIX_DATA)) else $error("held");
  a_frame_opens: assert property (MODE_SEL == 2'h1 && $rose(fsl) |-> ##[1:8] FRAME_ACTIVE) else $error("fopen");
  a_frame_closes: assert property (MODE_SEL == 2'h1 && $fell(fsl) |-> ##[1:8] !FRAME_ACTIVE) else $error("fend");
  a_line_opens: assert property (MODE_SEL == 2'h1 && $rose(lsl) |-> ##[1:8] LINE_ACTIVE) else $error("lopen");
  a_line_closes: assert property (MODE_SEL == 2'h1 && $fell(lsl) |-> ##[1:8] !LINE_ACTIVE) else $error("lend");
  a_nongated_noline: assert property ((MODE_SEL == 2'h2) [*4] |-> !LINE_ACTIVE) else $error("line");
  a_gated_in_frame: assert property (MODE_SEL == 2'h1 && $rose(PIX_VALID) |-> FRAME_ACTIVE) else $error("word");
  a_idle_quiet: assert property ((MODE_SEL == 2'h3 && PIX_READY) [*8] |-> !PIX_VALID) else $error("idle");
  a_drop_cause: assert property ($rose(OVERFLOW) |-> $past(PIX_VALID && !PIX_READY)) else $error("drop");
  a_drop_sticky: assert property (OVERFLOW |=> OVERFLOW) else $error("sticky");
endmodule // cspi_chk
bind cspi_top cspi_chk cspi_chk_i (.*);
`default_nettype wire

// file: test/cspi_sensor.sv
`timescale 1ns/1ps
`default_nettype none
// far-side sensor: pixel clock, syncs and data
module cspi_sensor (
  input wire logic fi,
  input wire logic li,
  output logic pclk,
  output logic fs,
  output logic ls,
  output logic [7:0] d
);
  logic f = 0; // frame level before polarity
  logic l = 0; // line level before polarity
  assign fs = f ^ fi;
  assign ls = l ^ li;
  initial pclk = 0; // clock stands low when idle
  initial d = 8'h5A;
  // one pixel; data no longer held after the fall
  task pix(input logic [7:0] v);
    d = v;
    #200 pclk = 1;
    #200 pclk = 0;
    d = ~v;
  endtask
  // n pixels from b; gated lines get a stray pixel each side
  task line(input int n, input logic [7:0] b, input logic g);
    if (g) pix(8'hEE);
    #400 l = g;
    #400;
    for (int i = 0; i < n; i++) pix(b + i[7:0]);
    #400 l = 0;
    #400;
    if (g) pix(8'hEE);
  endtask
  task frame(input int k, n, input logic [7:0] b, input logic g);
    #400 f = 1;
    #400;
    for (int j = 0; j < k; j++) line(n, b + 8'(j * n), g);
    #400 f = 0;
    #800;
  endtask
  task code(input logic [7:0] x);
    pix(8'hFF);
    pix(8'h00);
    pix(8'h00);
    pix(x);
  endtask
  // blanking, active start, n words, active end
  task emb(input int n, input logic [7:0] b);
    code(8'hB0);
    code(8'h80);
    for (int i = 0; i < n; i++) pix(b + i[7:0]);
    code(8'h90);
    code(8'hB0);
  endtask
endmodule // cspi_sensor
`default_nettype wire

// file: test/cspi_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cspi_top_tb_top;
  logic clk = 0;
  logic rst = 1;
  logic fi = 0;
  logic li = 0;
  logic rdy = 1;
  logic [1:0] mode = 2'h1;
  wire pclk, fs, ls, pst, pv, fa, la, ov;
  wire [7:0] sd, pd;
  int num_errors = 0;
  int samples_checked = 0;
  logic [8:0] rq[$]; // taken words with start flag
  always #25 clk = ~clk;
  cspi_top cspi_top_i (.CORE_CLK(clk), .RST(rst), .MODE_SEL(mode), .FRAME_POL_INV(fi), .LINE_POL_INV(li),
    .SENSOR_PIXEL_CLOCK(pclk), .SENSOR_FRAME_SYNC(fs), .SENSOR_LINE_SYNC(ls), .SENSOR_DATA(sd), .PIX_DATA(pd),
    .PIX_FRAME_START(pst), .PIX_VALID(pv), .PIX_READY(rdy), .FRAME_ACTIVE(fa), .LINE_ACTIVE(la), .OVERFLOW(ov));
  cspi_sensor cspi_sensor_i (.fi(fi), .li(li), .pclk(pclk), .fs(fs), .ls(ls), .d(sd));
  // collect every word the consumer takes
  always @(posedge clk) if (pv === 1'b1 && rdy) rq.push_back({pst, pd});
  task chk(input string n, input logic [8:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, exp, got);
    end
  endtask
  task setm(input logic [1:0] m, input logic a, c);
    @(posedge clk);
    mode <= m;
    fi <= a;
    li <= c;
    repeat (10) @(posedge clk);
  endtask
  task rd(input logic v);
    @(posedge clk);
    rdy <= v;
  endtask
  // c words counting from b, first one flagged s
  task words(input int c, input logic [7:0] b, input logic s);
    repeat (20) @(posedge clk);
    chk("count", 9'(rq.size()), 9'(c));
    for (int i = 0; i < c && rq.size() > 0; i++) chk("word", rq.pop_front(), {s && i == 0, b + i[7:0]});
    rq.delete();
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 0;
    setm(2'h1, 0, 0);
    cspi_sensor_i.frame(2, 3, 8'h10, 1);
    words(6, 8'h10, 1);
    setm(2'h1, 0, 1);
    cspi_sensor_i.frame(1, 3, 8'h40, 1);
    words(3, 8'h40, 1);
    setm(2'h2, 1, 0);
    cspi_sensor_i.frame(1, 5, 8'h60, 0);
    words(5, 8'h60, 1);
    setm(2'h0, 0, 0);
    cspi_sensor_i.emb(4, 8'h20);
    words(4, 8'h20, 1);
    setm(2'h2, 0, 0);
    rd(0);
    cspi_sensor_i.frame(1, 2, 8'h70, 0);
    chk("ovf", {8'h00, ov}, 9'h000);
    rd(1);
    words(2, 8'h70, 1);
    rd(0);
    cspi_sensor_i.frame(1, 4, 8'h80, 0);
    rd(1);
    // two words sit in the buffer and the third waits in the capture stage
    // the fourth word overwrites the third, so 80, 81 and 83 come out
    repeat (20) @(posedge clk);
    chk("count", 9'(rq.size()), 9'h003);
    chk("word", (rq.size() > 0) ? rq.pop_front() : 9'h000, 9'h180);
    chk("word", (rq.size() > 0) ? rq.pop_front() : 9'h000, 9'h081);
    chk("word", (rq.size() > 0) ? rq.pop_front() : 9'h000, 9'h083);
    rq.delete();
    chk("ovf", {8'h00, ov}, 9'h001);
    setm(2'h3, 0, 0);
    cspi_sensor_i.frame(1, 3, 8'h30, 1);
    words(0, 8'h30, 1);
    end_of_test;
  end
  // cut a hang short
  initial
  begin
    #1000000;
    num_errors++;
    end_of_test;
  end
endmodule // cspi_top_tb_top
`default_nettype wire
